// ### design/bto_pkg.sv
// Shared types and constants for the bridge ordering link.
// Assumes both ends run on one 250 MHz clock.
package bto_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int ADDR_W    = 32;
   localparam int DATA_W    = 32;
   localparam int BE_W      = 4;
   localparam int TAG_W     = 4;
   localparam int DIRS      = 2;
   localparam int PW_DEPTH  = 4;
   localparam int DT_DEPTH  = 4;
   localparam int BUF_DEPTH = 2;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int RETRY_GAP_NS  = 40;
   localparam int RETRY_GAP_CYC =
      (RETRY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_MEM_WR, CMD_MEM_WR_INV, CMD_IO_WR, CMD_CFG_WR,
      CMD_MEM_RD, CMD_IO_RD, CMD_CFG_RD
   } cmd_t;

   typedef enum logic [1:0] {CLS_POSTED, CLS_DLY_WR, CLS_DLY_RD} class_t;

   typedef enum logic [1:0] {
      ENT_FREE, ENT_QUEUED, ENT_ISSUED, ENT_DONE
   } ent_state_t;

   typedef struct packed {
      cmd_t              cmd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [BE_W-1:0]   be;
      logic [TAG_W-1:0]  tag;
   } txn_t;

   function automatic class_t cmd_class(input cmd_t c);
      case (c)
         CMD_MEM_WR, CMD_MEM_WR_INV: cmd_class = CLS_POSTED;
         CMD_IO_WR, CMD_CFG_WR:      cmd_class = CLS_DLY_WR;
         default:                    cmd_class = CLS_DLY_RD;
      endcase
   endfunction : cmd_class

endpackage : bto_pkg

// ### design/bto_link.sv
// Link between the bridge ordering end and the bus agent end.
// Arrays are indexed by the direction of the request.
`timescale 1ns/10ps
interface bto_link;
   localparam int D = bto_pkg::DIRS;
   logic                       req_valid  [D];
   bto_pkg::txn_t              req_txn    [D];
   logic                       term_valid [D];
   logic                       term_retry [D];
   logic [bto_pkg::TAG_W-1:0]  term_tag   [D];
   logic [bto_pkg::DATA_W-1:0] term_rdata [D];
   logic                       fwd_valid  [D];
   bto_pkg::txn_t              fwd_txn    [D];
   logic                       fwd_ready  [D];
   logic                       cpl_valid  [D];
   logic [bto_pkg::TAG_W-1:0]  cpl_tag    [D];
   logic [bto_pkg::DATA_W-1:0] cpl_data   [D];

   modport bridge (
      input  req_valid, req_txn, fwd_ready, cpl_valid, cpl_tag, cpl_data,
      output term_valid, term_retry, term_tag, term_rdata,
      output fwd_valid, fwd_txn
   );
   modport agent (
      output req_valid, req_txn, fwd_ready, cpl_valid, cpl_tag, cpl_data,
      input  term_valid, term_retry, term_tag, term_rdata,
      input  fwd_valid, fwd_txn
   );
endinterface : bto_link

// ### design/bus_agent_end.sv
// Bus agents on both sides: an initiator and a target per direction.
// Assumes the bridge end answers each request one cycle after it.
`timescale 1ns/10ps
module bus_agent_end #(
   parameter int RETRY_GAP_CYC = bto_pkg::RETRY_GAP_CYC
) (
   input  wire logic                       clock,
   input  wire logic                       rstn,
   bto_link.agent                          lnk,
   input  wire logic                       usr_req_valid [bto_pkg::DIRS],
   input  wire bto_pkg::txn_t              usr_req_txn   [bto_pkg::DIRS],
   output logic                            usr_req_ready [bto_pkg::DIRS],
   output logic                            usr_done      [bto_pkg::DIRS],
   output logic [bto_pkg::DATA_W-1:0]      usr_rdata     [bto_pkg::DIRS],
   input  wire logic                       usr_sink_ready[bto_pkg::DIRS],
   input  wire logic [bto_pkg::DATA_W-1:0] usr_sink_rdata[bto_pkg::DIRS],
   output logic                            usr_sink_valid[bto_pkg::DIRS],
   output bto_pkg::txn_t                   usr_sink_txn  [bto_pkg::DIRS]
);
   typedef enum logic [1:0] {INI_IDLE, INI_WAIT, INI_GAP} ini_state_t;
   localparam int GAP_W = $clog2(RETRY_GAP_CYC + 1);

   genvar d;
   generate
      for (d = 0; d < bto_pkg::DIRS; d++) begin : g_dir
         ini_state_t                state;
         logic [GAP_W-1:0]          gap;
         logic [bto_pkg::TAG_W-1:0] tag_ctr;
         logic                      take;

         assign take = usr_req_valid[d] && usr_req_ready[d];

         // -------------------------------------------------------
         // Initiator: one request outstanding, repeated on retry
         // -------------------------------------------------------
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               state            <= INI_IDLE;
               gap              <= '0;
               tag_ctr          <= '0;
               lnk.req_valid[d] <= 1'b0;
               lnk.req_txn[d]   <= '0;
               usr_req_ready[d] <= 1'b1;
               usr_done[d]      <= 1'b0;
               usr_rdata[d]     <= '0;
            end else begin
               usr_done[d] <= 1'b0;
               case (state)
                  INI_IDLE: begin
                     if (take) begin
                        lnk.req_txn[d]     <= usr_req_txn[d];
                        lnk.req_txn[d].tag <= tag_ctr;
                        tag_ctr            <= tag_ctr + 1'b1;
                        lnk.req_valid[d]   <= 1'b1;
                        usr_req_ready[d]   <= 1'b0;
                        state              <= INI_WAIT;
                     end
                  end
                  INI_WAIT: begin
                     lnk.req_valid[d] <= 1'b0;
                     if (lnk.term_valid[d]) begin
                        if (lnk.term_retry[d]) begin
                           gap   <= GAP_W'(RETRY_GAP_CYC);
                           state <= INI_GAP;
                        end else begin
                           usr_done[d]      <= 1'b1;
                           usr_rdata[d]     <= lnk.term_rdata[d];
                           usr_req_ready[d] <= 1'b1;
                           state            <= INI_IDLE;
                        end
                     end
                  end
                  INI_GAP: begin
                     // Repeat depends on nothing but its own timer
                     if (gap == GAP_W'(1)) begin
                        lnk.req_valid[d] <= 1'b1;
                        state            <= INI_WAIT;
                     end else begin
                        gap <= gap - 1'b1;
                     end
                  end
                  default: state <= INI_IDLE;
               endcase
            end
         end

         // -------------------------------------------------------
         // Target: takes forwarded work, answers delayed ones
         // -------------------------------------------------------
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               lnk.fwd_ready[d]  <= 1'b0;
               lnk.cpl_valid[d]  <= 1'b0;
               lnk.cpl_tag[d]    <= '0;
               lnk.cpl_data[d]   <= '0;
               usr_sink_valid[d] <= 1'b0;
               usr_sink_txn[d]   <= '0;
            end else begin
               // Posted acceptance ignores own master activity
               lnk.fwd_ready[d]  <= usr_sink_ready[d];
               lnk.cpl_valid[d]  <= 1'b0;
               usr_sink_valid[d] <= 1'b0;
               if (lnk.fwd_valid[d] && lnk.fwd_ready[d]) begin
                  usr_sink_valid[d] <= 1'b1;
                  usr_sink_txn[d]   <= lnk.fwd_txn[d];
                  if (bto_pkg::cmd_class(lnk.fwd_txn[d].cmd) !=
                      bto_pkg::CLS_POSTED) begin
                     lnk.cpl_valid[d] <= 1'b1;
                     lnk.cpl_tag[d]   <= lnk.fwd_txn[d].tag;
                     lnk.cpl_data[d]  <= usr_sink_rdata[d];
                  end
               end
            end
         end
      end
   endgenerate
endmodule : bus_agent_end

// ### design/bridge_order_end.sv
// Transaction ordering engine of a two-port bridge, both directions.
// Assumes agents repeat retried requests with the same tag, cmd, addr.
`timescale 1ns/10ps
module bridge_order_end #(
   parameter int PW_DEPTH = bto_pkg::PW_DEPTH,
   parameter int DT_DEPTH = bto_pkg::DT_DEPTH
) (
   input  wire logic clock,
   input  wire logic rstn,
   bto_link.bridge   lnk,
   output logic      pw_full [bto_pkg::DIRS],
   output logic      dt_full [bto_pkg::DIRS]
);
   localparam int PEND_W = $clog2(PW_DEPTH + bto_pkg::BUF_DEPTH + 1);
   localparam int PTR_W  = (PW_DEPTH > 1) ? $clog2(PW_DEPTH) : 1;
   localparam int DIX_W  = (DT_DEPTH > 1) ? $clog2(DT_DEPTH) : 1;
   localparam int BCNT_W = $clog2(bto_pkg::BUF_DEPTH + 1);

   // Posted writes accepted but not yet taken by the far target
   logic [PEND_W-1:0] pw_pend [bto_pkg::DIRS];
   logic              pw_done [bto_pkg::DIRS];

   genvar d;
   generate
      // Each direction is a separate engine sharing only pw_pend and pw_done
      for (d = 0; d < bto_pkg::DIRS; d++) begin : g_dir
         localparam int R = bto_pkg::DIRS - 1 - d;
         bto_pkg::txn_t       pw_mem   [PW_DEPTH];
         logic [PTR_W-1:0]    pw_wr;
         logic [PTR_W-1:0]    pw_rd;
         logic [PEND_W-1:0]   pw_fill;
         bto_pkg::txn_t       dt_txn   [DT_DEPTH];
         bto_pkg::ent_state_t dt_st    [DT_DEPTH];
         logic [PEND_W-1:0]   dt_ahead [DT_DEPTH];
         logic [bto_pkg::DATA_W-1:0] dt_rdata [DT_DEPTH];
         bto_pkg::txn_t       req;
         bto_pkg::txn_t       buf_in;
         bto_pkg::txn_t       slot1;
         logic [BCNT_W-1:0]   buf_cnt;
         logic [BCNT_W-1:0]   next_buf_cnt;
         logic req_post, hit, has_free, dly_rdy, prio_pw;
         logic pw_push, dt_alloc, dt_retire, grant_pw, grant_dt;
         logic buf_room, buf_push, buf_pop;
         logic [DIX_W-1:0] hit_ix, free_ix, dly_ix;

         assign req = lnk.req_txn[d];

         // -------------------------------------------------------
         // Queue lookup
         // -------------------------------------------------------
         always_comb begin
            req_post = bto_pkg::cmd_class(req.cmd) == bto_pkg::CLS_POSTED;
            hit      = 1'b0;
            hit_ix   = '0;
            has_free = 1'b0;
            free_ix  = '0;
            dly_rdy  = 1'b0;
            dly_ix   = '0;
            for (int i = DT_DEPTH - 1; i >= 0; i--) begin
               if (dt_st[i] != bto_pkg::ENT_FREE && dt_txn[i].tag == req.tag
                   && dt_txn[i].cmd == req.cmd
                   && dt_txn[i].addr == req.addr) begin
                  hit    = 1'b1;
                  hit_ix = DIX_W'(i);
               end
               if (dt_st[i] == bto_pkg::ENT_FREE) begin
                  has_free = 1'b1;
                  free_ix  = DIX_W'(i);
               end
               // Any queued entry with no older posted write may go
               if (dt_st[i] == bto_pkg::ENT_QUEUED
                   && dt_ahead[i] == '0) begin
                  dly_rdy = 1'b1;
                  dly_ix  = DIX_W'(i);
               end
            end
         end

         // -------------------------------------------------------
         // Decisions
         // -------------------------------------------------------
         // Posted acceptance looks only at posted room
         assign pw_push = lnk.req_valid[d] && req_post
                          && pw_fill < PEND_W'(PW_DEPTH);
         assign dt_retire = lnk.req_valid[d] && !req_post && hit
                            && dt_st[hit_ix] == bto_pkg::ENT_DONE
                            && dt_ahead[hit_ix] == '0;
         assign dt_alloc = lnk.req_valid[d] && !req_post && !hit
                           && has_free;
         assign buf_room = buf_cnt != BCNT_W'(bto_pkg::BUF_DEPTH);
         assign grant_pw = buf_room && pw_fill != '0
                           && (prio_pw || !dly_rdy);
         assign grant_dt = buf_room && dly_rdy && !grant_pw;
         assign buf_push = grant_pw || grant_dt;
         assign buf_pop  = lnk.fwd_valid[d] && lnk.fwd_ready[d];
         // Each entry leaves whole with its own enables
         assign buf_in   = grant_pw ? pw_mem[pw_rd]
                                    : dt_txn[dly_ix];
         assign pw_done[d] = buf_pop && bto_pkg::cmd_class(
                             lnk.fwd_txn[d].cmd) == bto_pkg::CLS_POSTED;
         assign next_buf_cnt = buf_cnt + BCNT_W'(buf_push)
                               - BCNT_W'(buf_pop);

         // -------------------------------------------------------
         // Posted write queue
         // -------------------------------------------------------
         always_ff @(posedge clock) begin
            if (pw_push)
               pw_mem[pw_wr] <= req;
         end

         // Strict first-in first-out order
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               pw_wr      <= '0;
               pw_rd      <= '0;
               pw_fill    <= '0;
               pw_pend[d] <= '0;
               pw_full[d] <= 1'b0;
            end else begin
               if (pw_push)
                  pw_wr <= (pw_wr == PTR_W'(PW_DEPTH - 1)) ? '0
                                                           : pw_wr + 1'b1;
               if (grant_pw)
                  pw_rd <= (pw_rd == PTR_W'(PW_DEPTH - 1)) ? '0
                                                           : pw_rd + 1'b1;
               pw_fill    <= pw_fill + PEND_W'(pw_push) - PEND_W'(grant_pw);
               pw_pend[d] <= pw_pend[d] + PEND_W'(pw_push)
                             - PEND_W'(pw_done[d]);
               pw_full[d] <= pw_fill + PEND_W'(pw_push) - PEND_W'(grant_pw)
                             == PEND_W'(PW_DEPTH);
            end
         end

         // -------------------------------------------------------
         // Delayed transaction queue
         // -------------------------------------------------------
         always_ff @(posedge clock) begin
            for (int i = 0; i < DT_DEPTH; i++) begin
               if (dt_alloc && free_ix == DIX_W'(i))
                  dt_txn[i] <= req;
            end
         end

         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               for (int i = 0; i < DT_DEPTH; i++) begin
                  dt_st[i]    <= bto_pkg::ENT_FREE;
                  dt_ahead[i] <= '0;
                  dt_rdata[i] <= '0;
               end
            end else begin
               for (int i = 0; i < DT_DEPTH; i++) begin
                  if (dt_ahead[i] != '0
                      && ((dt_st[i] == bto_pkg::ENT_QUEUED && pw_done[d])
                      || (dt_st[i] == bto_pkg::ENT_DONE && pw_done[R])))
                     dt_ahead[i] <= dt_ahead[i] - 1'b1;
                  if (dt_alloc && free_ix == DIX_W'(i)) begin
                     dt_st[i]    <= bto_pkg::ENT_QUEUED;
                     dt_ahead[i] <= pw_pend[d] - PEND_W'(pw_done[d]);
                  end
                  if (grant_dt && dly_ix == DIX_W'(i))
                     dt_st[i] <= bto_pkg::ENT_ISSUED;
                  if (lnk.cpl_valid[d] && dt_st[i] == bto_pkg::ENT_ISSUED
                      && dt_txn[i].tag == lnk.cpl_tag[d]) begin
                     dt_st[i]    <= bto_pkg::ENT_DONE;
                     dt_rdata[i] <= lnk.cpl_data[d];
                     // Read data pulls reverse posted writes; writes don't
                     dt_ahead[i] <= (bto_pkg::cmd_class(dt_txn[i].cmd)
                                     == bto_pkg::CLS_DLY_RD)
                                    ? pw_pend[R] - PEND_W'(pw_done[R])
                                    : '0;
                  end
                  if (dt_retire && hit_ix == DIX_W'(i))
                     dt_st[i] <= bto_pkg::ENT_FREE;
               end
            end
         end

         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn)
               dt_full[d] <= 1'b0;
            else
               dt_full[d] <= !has_free && !dt_retire;
         end

         // -------------------------------------------------------
         // Termination answer to the initiator
         // -------------------------------------------------------
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               lnk.term_valid[d] <= 1'b0;
               lnk.term_retry[d] <= 1'b0;
               lnk.term_tag[d]   <= '0;
               lnk.term_rdata[d] <= '0;
            end else begin
               lnk.term_valid[d] <= lnk.req_valid[d];
               // A posted write takes its place on a non-retry end; a delayed one on a repeat once its entry is done and its dt_ahead is zero
               lnk.term_retry[d] <= !(pw_push || dt_retire);
               lnk.term_tag[d]   <= req.tag;
               lnk.term_rdata[d] <= dt_rdata[hit_ix];
            end
         end

         // -------------------------------------------------------
         // Arbiter and two-entry output buffer
         // -------------------------------------------------------
         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn)
               prio_pw <= 1'b1;
            else if (grant_pw)
               prio_pw <= 1'b0;
            else if (grant_dt)
               prio_pw <= 1'b1;
         end

         always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
               buf_cnt          <= '0;
               lnk.fwd_valid[d] <= 1'b0;
               lnk.fwd_txn[d]   <= '0;
               slot1            <= '0;
            end else begin
               buf_cnt          <= next_buf_cnt;
               lnk.fwd_valid[d] <= next_buf_cnt != '0;
               case ({buf_push, buf_pop})
                  2'b10: begin
                     if (buf_cnt == '0)
                        lnk.fwd_txn[d] <= buf_in;
                     else
                        slot1 <= buf_in;
                  end
                  2'b01: lnk.fwd_txn[d] <= slot1;
                  2'b11: begin
                     if (buf_cnt == BCNT_W'(bto_pkg::BUF_DEPTH)) begin
                        lnk.fwd_txn[d] <= slot1;
                        slot1          <= buf_in;
                     end else begin
                        lnk.fwd_txn[d] <= buf_in;
                     end
                  end
                  default: ;
               endcase
            end
         end
      end
   endgenerate
endmodule : bridge_order_end

// ### sim/bto_link_properties.sv
// Checker on the link between the two ends.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module bto_link_properties #(
   parameter int D = bto_pkg::DIRS
) (
   input wire logic                      clock,
   input wire logic                      rstn,
   input wire logic                      req_valid  [D],
   input wire bto_pkg::txn_t             req_txn    [D],
   input wire logic                      term_valid [D],
   input wire logic [bto_pkg::TAG_W-1:0] term_tag   [D],
   input wire logic                      fwd_valid  [D],
   input wire bto_pkg::txn_t             fwd_txn    [D],
   input wire logic                      fwd_ready  [D],
   input wire logic                      cpl_valid  [D],
   input wire logic [bto_pkg::TAG_W-1:0] cpl_tag    [D]
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);
   for (genvar d = 0; d < D; d++) begin : g_dir
      property p_term_answer;
         req_valid[d] |=> term_valid[d];
      endproperty
      a_term_answer: assert property (p_term_answer)
         else $error("request not answered next cycle");
      property p_term_quiet;
         !req_valid[d] |=> !term_valid[d];
      endproperty
      a_term_quiet: assert property (p_term_quiet)
         else $error("answer without request");
      property p_term_tag;
         req_valid[d] |=> term_tag[d] == $past(req_txn[d].tag);
      endproperty
      a_term_tag: assert property (p_term_tag)
         else $error("answer carries wrong tag");
      property p_fwd_hold;
         fwd_valid[d] && !fwd_ready[d] |=> fwd_valid[d] && $stable(fwd_txn[d]);
      endproperty
      a_fwd_hold: assert property (p_fwd_hold)
         else $error("forwarded txn changed while stalled");
      property p_cpl_cause;
         cpl_valid[d] |-> $past(fwd_valid[d] && fwd_ready[d]);
      endproperty
      a_cpl_cause: assert property (p_cpl_cause)
         else $error("completion without forward");
      property p_posted_no_cpl;
         fwd_valid[d] && fwd_ready[d] && fwd_txn[d].cmd inside
            {bto_pkg::CMD_MEM_WR, bto_pkg::CMD_MEM_WR_INV} |=> !cpl_valid[d];
      endproperty
      a_posted_no_cpl: assert property (p_posted_no_cpl)
         else $error("posted write produced a completion");
      property p_delayed_cpl;
         fwd_valid[d] && fwd_ready[d] && !(fwd_txn[d].cmd inside
            {bto_pkg::CMD_MEM_WR, bto_pkg::CMD_MEM_WR_INV})
            |=> cpl_valid[d] && cpl_tag[d] == $past(fwd_txn[d].tag);
      endproperty
      a_delayed_cpl: assert property (p_delayed_cpl)
         else $error("delayed txn completion missing or mistagged");
      property p_one_outstanding;
         req_valid[d] |=> !req_valid[d];
      endproperty
      a_one_outstanding: assert property (p_one_outstanding)
         else $error("back to back attempts from one initiator");
      c_stall: cover property (fwd_valid[d] && !fwd_ready[d]);
      c_cpl: cover property (cpl_valid[d]);
      c_posted: cover property (term_valid[d] ##1 fwd_valid[d]);
   end
endmodule : bto_link_properties

// ### sim/tb.sv
// Self-checking bench for both ends.
// Assumes the package, link and both ends are compiled first.
`timescale 1ns/10ps
module tb;
   localparam int D = bto_pkg::DIRS;
   logic                       clock;
   logic                       rstn;
   logic                       usr_req_valid  [D];
   bto_pkg::txn_t              usr_req_txn    [D];
   logic                       usr_req_ready  [D];
   logic                       usr_done       [D];
   logic [bto_pkg::DATA_W-1:0] usr_rdata      [D];
   logic                       usr_sink_ready [D];
   logic [bto_pkg::DATA_W-1:0] usr_sink_rdata [D];
   logic                       usr_sink_valid [D];
   bto_pkg::txn_t              usr_sink_txn   [D];
   logic                       pw_full        [D];
   logic                       dt_full        [D];
   bto_pkg::txn_t              got            [D][$];
   int                         fails;
   int                         cmp_count;
   bto_link lnk ();
   bridge_order_end bridge_order_end_inst (.clock(clock), .rstn(rstn),
      .lnk(lnk), .pw_full(pw_full), .dt_full(dt_full));
   bus_agent_end #(.RETRY_GAP_CYC(2)) bus_agent_end_inst (.clock(clock),
      .rstn(rstn), .lnk(lnk), .usr_req_valid(usr_req_valid),
      .usr_req_txn(usr_req_txn), .usr_req_ready(usr_req_ready),
      .usr_done(usr_done), .usr_rdata(usr_rdata),
      .usr_sink_ready(usr_sink_ready), .usr_sink_rdata(usr_sink_rdata),
      .usr_sink_valid(usr_sink_valid), .usr_sink_txn(usr_sink_txn));
   bto_link_properties bto_link_properties_inst (.clock(clock), .rstn(rstn),
      .req_valid(lnk.req_valid), .req_txn(lnk.req_txn),
      .term_valid(lnk.term_valid), .term_tag(lnk.term_tag),
      .fwd_valid(lnk.fwd_valid), .fwd_txn(lnk.fwd_txn),
      .fwd_ready(lnk.fwd_ready), .cpl_valid(lnk.cpl_valid),
      .cpl_tag(lnk.cpl_tag));
   // -------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   task automatic hang();
      fails++;
      $display("wrong value wait expected event seen timeout");
      end_of_test();
   endtask : hang
   task automatic check(input string w, input logic [31:0] e, s);
      cmp_count++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", w, e, s);
      end
   endtask : check
   task automatic send(input int d, input bto_pkg::cmd_t c,
                       input logic [31:0] a, v, input logic [3:0] b);
      #1;
      for (int n = 0; usr_req_ready[d] !== 1'b1; n++) begin
         if (n > 2000) hang();
         @(posedge clock);
         #1;
      end
      @(posedge clock);
      usr_req_valid[d] <= 1'b1;
      usr_req_txn[d] <= '{cmd: c, addr: a, data: v, be: b, tag: 4'h0};
      @(posedge clock);
      usr_req_valid[d] <= 1'b0;
   endtask : send
   task automatic wait_got(input int d, input int cnt);
      for (int n = 0; got[d].size() < cnt; n++) begin
         if (n > 2000) hang();
         @(posedge clock);
      end
   endtask : wait_got
   task automatic wait_done(input int d);
      for (int n = 0; usr_done[d] !== 1'b1; n++) begin
         if (n > 2000) hang();
         @(posedge clock);
         #1;
      end
   endtask : wait_done
   // -------------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------------
   task automatic t_cmds();
      got[1].delete();
      for (int k = 0; k < 7; k++) begin
         send(1, bto_pkg::cmd_t'(k), 32'h1000, 32'(k), 4'hf);
         wait_done(1);
         wait_got(1, k + 1);
         check("cmd", 32'(k), 32'(got[1][k].cmd));
      end
   endtask : t_cmds
   task automatic t_same_addr();
      got[0].delete();
      for (int k = 0; k < 3; k++)
         send(0, bto_pkg::CMD_MEM_WR, 32'h2000, 32'h1111_0000 + k,
              4'(1 << k));
      wait_got(0, 3);
      for (int k = 0; k < 3; k++) begin
         check("data", 32'h1111_0000 + k, got[0][k].data);
         check("be", 32'(1 << k), 32'(got[0][k].be));
      end
   endtask : t_same_addr
   task automatic t_read_push();
      logic hit = 1'b0;
      got[0].delete();
      got[1].delete();
      @(posedge clock);
      usr_sink_ready[0] <= 1'b0;
      usr_sink_ready[1] <= 1'b0;
      usr_sink_rdata[0] <= 32'hbeef_0001;
      send(0, bto_pkg::CMD_MEM_WR, 32'h3000, 32'h2222_0000, 4'hf);
      send(1, bto_pkg::CMD_MEM_WR, 32'h4000, 32'h3333_0000, 4'hf);
      send(0, bto_pkg::CMD_MEM_RD, 32'h3000, 32'h0, 4'hf);
      repeat (30) @(posedge clock);
      usr_sink_ready[0] <= 1'b1;
      wait_got(0, 2);
      check("first", 32'h2222_0000, got[0][0].data);
      check("second", 32'(bto_pkg::CMD_MEM_RD), 32'(got[0][1].cmd));
      for (int n = 0; n < 40; n++) begin
         @(posedge clock);
         #1;
         hit |= usr_done[0] === 1'b1;
      end
      check("early done", 32'h0, 32'(hit));
      @(posedge clock);
      usr_sink_ready[1] <= 1'b1;
      wait_done(0);
      check("rdata", 32'hbeef_0001, usr_rdata[0]);
      check("reverse", 32'h3333_0000, got[1][0].data);
   endtask : t_read_push
   task automatic t_full();
      got[0].delete();
      @(posedge clock);
      usr_sink_ready[0] <= 1'b0;
      for (int k = 0; k < 7; k++)
         send(0, bto_pkg::CMD_MEM_WR_INV, 32'h5000, 32'h4444_0000 + k, 4'hf);
      repeat (20) @(posedge clock);
      #1;
      check("full", 32'h1, 32'(pw_full[0]));
      check("dt full", 32'h0, 32'(dt_full[0]));
      check("retried", 32'h0, 32'(usr_req_ready[0]));
      @(posedge clock);
      usr_sink_ready[0] <= 1'b1;
      wait_got(0, 7);
      for (int k = 0; k < 7; k++)
         check("order", 32'h4444_0000 + k, got[0][k].data);
   endtask : t_full
   // -------------------------------------------------------------------
   // Clock, collector, main
   // -------------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   always @(negedge clock) begin
      for (int i = 0; i < 2; i++)
         if (usr_sink_valid[i] === 1'b1) got[i].push_back(usr_sink_txn[i]);
   end
   initial begin
      fails = 0;
      cmp_count = 0;
      rstn = 1'b0;
      for (int d = 0; d < 2; d++) begin
         usr_req_valid[d] = 1'b0;
         usr_req_txn[d] = '0;
         usr_sink_ready[d] = 1'b1;
         usr_sink_rdata[d] = 32'h0;
      end
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      t_cmds();
      t_same_addr();
      t_read_push();
      t_full();
      end_of_test();
   end
endmodule : tb
